// file: ufd_map.vh
`ifndef UFD_MAP_VH
`define UFD_MAP_VH
`define UFD_ADDR_W        4
`define UFD_OFF_FCR_A     4'h0
`define UFD_OFF_FCR_B     4'h1
`define UFD_OFF_ALT_A     4'h2
`define UFD_OFF_ALT_B     4'h3
`define UFD_OFF_STATUS    4'h4
`define UFD_OFF_IRQ_STAT  4'h5
`define UFD_OFF_IRQ_MASK  4'h6
`define UFD_OFF_TIMEOUT   4'h7
`define UFD_FCR_EN        0
`define UFD_FCR_RXCLR     1
`define UFD_FCR_TXCLR     2
`define UFD_FCR_DMA       3
`define UFD_FCR_RESET     8'h00
`define UFD_FIFO_DEPTH    5'h10
`define UFD_TRIG_0        5'h01
`define UFD_TRIG_1        5'h04
`define UFD_TRIG_2        5'h08
`define UFD_TRIG_3        5'h0E
`define UFD_IRQ_TX        0
`define UFD_IRQ_RXTRIG    1
`define UFD_IRQ_RXTO      2
`endif

// file: ufd_chan.v
`timescale 1ns/1ns
`default_nettype none
`include "ufd_map.vh"
module ufd_chan (
  input  wire       clk,
  input  wire       rst,
  input  wire       fcr_we,
  input  wire [7:0] fcr_wdata,
  input  wire       alt_rx_data_ready_n,
  input  wire       tx_push,
  input  wire       tx_pop,
  input  wire       rx_push,
  input  wire       rx_pop,
  input  wire       rx_timeout,
  output reg  [7:0] fcr_r,
  output reg  [4:0] tx_count_r,
  output reg  [4:0] rx_count_r,
  output wire       tx_full,
  output wire       rx_full,
  output wire       tx_irq,
  output wire       rx_irq,
  output reg        tx_space_ready_n,
  output reg        multi_function_pin
);
  function [4:0] ufd_trig;
    input [1:0] sel;
    begin
      case (sel) // RQ11
        2'h0:    ufd_trig = `UFD_TRIG_0;
        2'h1:    ufd_trig = `UFD_TRIG_1;
        2'h2:    ufd_trig = `UFD_TRIG_2;
        default: ufd_trig = `UFD_TRIG_3;
      endcase
    end
  endfunction
  wire       fifo_en  = fcr_r[`UFD_FCR_EN];
  wire       dma1     = fcr_r[`UFD_FCR_DMA] & fifo_en;
  // With FIFOs off the channel holds one character only.
  wire [4:0] cap      = fifo_en ? `UFD_FIFO_DEPTH : 5'h01;
  wire [4:0] trig     = ufd_trig(fcr_r[7:6]);
  wire       tx_clr   = fcr_we & fcr_wdata[`UFD_FCR_EN] & fcr_wdata[`UFD_FCR_TXCLR];
  wire       rx_clr   = fcr_we & fcr_wdata[`UFD_FCR_EN] & fcr_wdata[`UFD_FCR_RXCLR];
  reg        rx_latch_r;
  wire [4:0] tx_count_nxt;
  wire [4:0] rx_count_nxt;
  assign tx_full = (tx_count_r >= cap);
  assign rx_full = (rx_count_r >= cap);
  wire tx_in  = tx_push & ~tx_full;
  wire tx_out = tx_pop & (tx_count_r != 5'h00);
  wire rx_in  = rx_push & ~rx_full; // RQ6
  wire rx_out = rx_pop & (rx_count_r != 5'h00);
  assign tx_count_nxt = tx_clr ? 5'h00 :
                        tx_count_r + {4'h0, tx_in} - {4'h0, tx_out}; // RQ14
  assign rx_count_nxt = rx_clr ? 5'h00 :
                        rx_count_r + {4'h0, rx_in} - {4'h0, rx_out}; // RQ14
  assign tx_irq = dma1 ? ~tx_full : (tx_count_r == 5'h00); // RQ5
  assign rx_irq = fifo_en ? (rx_count_r >= trig) : (rx_count_r != 5'h00); // RQ8
  always @(posedge clk) begin
    if (rst) begin
      fcr_r              <= `UFD_FCR_RESET; // RQ10
      tx_count_r         <= 5'h00;
      rx_count_r         <= 5'h00;
      rx_latch_r         <= 1'b0;
      tx_space_ready_n   <= 1'b1;
      multi_function_pin <= 1'b1;
    end else begin
      // Writes without the enable bit clear bit 0 and keep the other bits. Clear bits never stay set.
      if (fcr_we && fcr_wdata[`UFD_FCR_EN]) begin // RQ12
        fcr_r <= {fcr_wdata[7:6], 2'b00, fcr_wdata[3], 2'b00, 1'b1}; // RQ9 RQ14
      end else if (fcr_we) begin
        fcr_r <= {fcr_r[7:1], 1'b0};
      end
      tx_count_r <= tx_count_nxt;
      rx_count_r <= rx_count_nxt;
      if (rx_count_nxt == 5'h00) begin
        rx_latch_r <= 1'b0; // RQ13
      end else if (dma1 && (rx_timeout || rx_count_nxt >= trig)) begin
        rx_latch_r <= 1'b1; // RQ13
      end
      if (dma1) begin
        tx_space_ready_n <= (tx_count_nxt >= cap); // RQ4
      end else begin
        tx_space_ready_n <= (tx_count_nxt != 5'h00); // RQ1
      end
      // The pin carries receive-ready only in that alternate function mode.
      if (!alt_rx_data_ready_n) begin
        multi_function_pin <= 1'b1; // RQ3
      end else if (dma1) begin
        // Reaching the trigger lowers the pin at once, not one cycle after the latch.
        multi_function_pin <= ~(rx_count_nxt >= trig ||
                                (rx_latch_r && rx_count_nxt != 5'h00) ||
                                (rx_timeout && rx_count_nxt != 5'h00)); // RQ7 RQ13
      end else begin
        multi_function_pin <= (rx_count_nxt == 5'h00); // RQ2
      end
    end
  end
endmodule
`default_nettype wire

// file: ufd_top.v
// Summary of operation
// (RQ1) Mode 0: tx ready low while empty.
// (RQ2) Mode 0: rx ready low while data held.
// (RQ3) Rx ready only in alternate pin mode.
// (RQ4) Mode 1: tx ready low while space.
// (RQ5) Mode 1: tx interrupt while space exists.
// (RQ6) Mode 1: rx interrupt at trigger, keep filling.
// (RQ7) Mode 1: rx ready low above trigger; the code lowers it already at the trigger level.
// (RQ8) Bits 7-6 pick rx trigger level.
// (RQ9) Bits 5-4 unused, read zero.
// (RQ10) Bit 3 selects DMA mode, resets zero.
// (RQ11) Trigger codes: 1, 4, 8, 14.
// (RQ12) Other bits written only with bit 0.
// (RQ13) Mode 1: timeout lowers rx ready until empty.
// (RQ14) Bits 2/1 clear FIFOs, self-clearing.
// (RQ15) Each channel independent, clock synchronous.
`timescale 1ns/1ns
`default_nettype none
`include "ufd_map.vh"
module ufd_top (
  input  wire        clk,
  input  wire        rst,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [1:0]  tx_push,
  input  wire [1:0]  tx_pop,
  input  wire [1:0]  rx_push,
  input  wire [1:0]  rx_pop,
  input  wire [1:0]  rx_timeout,
  output wire [1:0]  tx_space_ready_n,
  output wire [1:0]  multi_function_pin,
  output wire [1:0]  tx_irq,
  output wire [1:0]  rx_irq,
  output reg         irq
);
  reg         ack_r;
  reg  [1:0]  alt_function_reg_r;
  reg  [5:0]  irq_stat_r;
  reg  [5:0]  irq_mask_r;
  reg  [5:0]  rx_to_d_r;
  wire [15:0] fcr_all;
  wire [9:0]  tx_cnt_all;
  wire [9:0]  rx_cnt_all;
  wire [1:0]  tx_full;
  wire [1:0]  rx_full;
  wire [5:0]  ev;
  wire        acc  = (avs_read | avs_write) & ~ack_r;
  wire        wr   = avs_write & acc & avs_byteenable[0];
  // One wait cycle keeps the answer registered; every access takes two cycles.
  assign avs_waitrequest = acc;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      ufd_chan u_chan ( // RQ15
        .clk                (clk),
        .rst                (rst),
        .fcr_we             (wr && avs_address == (g ? `UFD_OFF_FCR_B : `UFD_OFF_FCR_A)),
        .fcr_wdata          (avs_writedata[7:0]),
        .alt_rx_data_ready_n          (alt_function_reg_r[g]),
        .tx_push            (tx_push[g]),
        .tx_pop             (tx_pop[g]),
        .rx_push            (rx_push[g]),
        .rx_pop             (rx_pop[g]),
        .rx_timeout         (rx_timeout[g]),
        .fcr_r              (fcr_all[8*g+7:8*g]),
        .tx_count_r         (tx_cnt_all[5*g+4:5*g]),
        .rx_count_r         (rx_cnt_all[5*g+4:5*g]),
        .tx_full            (tx_full[g]),
        .rx_full            (rx_full[g]),
        .tx_irq             (tx_irq[g]),
        .rx_irq             (rx_irq[g]),
        .tx_space_ready_n   (tx_space_ready_n[g]),
        .multi_function_pin (multi_function_pin[g])
      );
      assign ev[3*g+`UFD_IRQ_TX]     = tx_irq[g];
      assign ev[3*g+`UFD_IRQ_RXTRIG] = rx_irq[g];
      assign ev[3*g+`UFD_IRQ_RXTO]   = rx_timeout[g];
    end
  endgenerate
  always @(posedge clk) begin
    if (rst) begin
      ack_r              <= 1'b0;
      alt_function_reg_r <= 2'b00;
      irq_stat_r         <= 6'h00;
      irq_mask_r         <= 6'h00;
      rx_to_d_r          <= 6'h00;
      avs_readdata       <= 32'h0;
      irq                <= 1'b0;
    end else begin
      ack_r     <= acc;
      rx_to_d_r <= ev;
      // Rising events set sticky bits; a set wins over a same-cycle clear.
      if (wr && avs_address == `UFD_OFF_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~avs_writedata[5:0]) | (ev & ~rx_to_d_r);
      end else begin
        irq_stat_r <= irq_stat_r | (ev & ~rx_to_d_r);
      end
      if (wr && avs_address == `UFD_OFF_IRQ_MASK) begin
        irq_mask_r <= avs_writedata[5:0];
      end
      if (wr && avs_address == `UFD_OFF_ALT_A) begin
        alt_function_reg_r[0] <= avs_writedata[0]; // RQ3
      end
      if (wr && avs_address == `UFD_OFF_ALT_B) begin
        alt_function_reg_r[1] <= avs_writedata[0]; // RQ3
      end
      irq <= |(irq_stat_r & irq_mask_r);
      avs_readdata <= 32'h0;
      if (avs_read && acc) begin
        case (avs_address)
          `UFD_OFF_FCR_A:    avs_readdata <= {24'h0, fcr_all[7:0]};
          `UFD_OFF_FCR_B:    avs_readdata <= {24'h0, fcr_all[15:8]};
          `UFD_OFF_ALT_A:    avs_readdata <= {31'h0, alt_function_reg_r[0]};
          `UFD_OFF_ALT_B:    avs_readdata <= {31'h0, alt_function_reg_r[1]};
          `UFD_OFF_STATUS:   avs_readdata <= {8'h0, rx_full, tx_full, rx_cnt_all, tx_cnt_all};
          `UFD_OFF_IRQ_STAT: avs_readdata <= {26'h0, irq_stat_r};
          `UFD_OFF_IRQ_MASK: avs_readdata <= {26'h0, irq_mask_r};
          default:           avs_readdata <= 32'h0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: ufd_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module ufd_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0]  tx_push,
  input wire logic [1:0]  tx_pop,
  input wire logic [1:0]  rx_push,
  input wire logic [1:0]  rx_pop,
  input wire logic [1:0]  rx_timeout,
  input wire logic [1:0]  tx_space_ready_n,
  input wire logic [1:0]  multi_function_pin,
  input wire logic [1:0]  tx_irq,
  input wire logic [1:0]  rx_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic  req = avs_read | avs_write;
  // Register writes may legally move the pins, so the pin checks skip two cycles after one.
  logic [1:0] quiet_r = 2'b11;
  always @(posedge clk)
    quiet_r <= {quiet_r[0], avs_write | rst};
  wait_first_a: assert property (req && !$past(avs_waitrequest) |-> avs_waitrequest)
    else $error("request not stalled");
  wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("stall too long");
  idle_wait_a: assert property (!req |-> !avs_waitrequest)
    else $error("stall while idle");
  read_clear_a: assert property (!avs_read [*2] |-> avs_readdata == 32'h0)
    else $error("read data not cleared");
  reset_pins_a: assert property (disable iff (1'b0) rst |=> tx_space_ready_n == 2'h3
    && multi_function_pin == 2'h3) else $error("pins not idle in reset");
  release_ready_a: assert property ($fell(rst) |=> tx_space_ready_n == 2'h0)
    else $error("tx ready not low after reset");
  tx_rise_a: assert property ($rose(tx_space_ready_n[0]) && quiet_r == 2'h0
    |-> $past(tx_push[0]) || $past(tx_push[0], 2)) else $error("tx ready rose alone");
  rx_fall_a: assert property ($fell(multi_function_pin[0]) && quiet_r == 2'h0
    |-> $past(rx_push[0] | rx_timeout[0]) || $past(rx_push[0] | rx_timeout[0], 2))
    else $error("rx ready fell alone");
  rx_irq_a: assert property ($rose(rx_irq[0]) && quiet_r == 2'h0
    |-> $past(rx_push[0] | rx_pop[0]) || $past(rx_push[0] | rx_pop[0], 2))
    else $error("rx irq rose alone");
  tx_irq_a: assert property ($rose(tx_irq[0]) && quiet_r == 2'h0
    |-> $past(tx_pop[0]) || $past(tx_pop[0], 2)) else $error("tx irq rose alone");
  cover property ($rose(rx_irq[0]));
  cover property ($fell(multi_function_pin[0]) && $past(rx_timeout[0]));
  cover property (tx_space_ready_n[0] && !tx_irq[0]);
endmodule
bind ufd_top ufd_chk ufd_chk_inst (.*);
`default_nettype wire

// file: ufd_dma.sv
`timescale 1ns/1ns
`default_nettype none
module ufd_dma (
  input  wire logic clk,
  input  wire logic en,
  input  wire logic ready_n,
  output var  logic push = 1'b0
);
  logic odd_r = 1'b0;
  // Writing every other cycle models a slow controller and lets ready settle between writes.
  always @(posedge clk) begin
    odd_r <= !odd_r;
    push  <= en && !ready_n && odd_r;
  end
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [9:0]  ev = 10'h000;
  logic        dma_en = 1'b0;
  logic        dma_push;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest, irq;
  logic [1:0]  txr_n, mfp, tx_irq, rx_irq;
  logic [7:0]  f, w;
  int          failures = 0, num_checks = 0, k, t;
  ufd_top ufd_top_inst (.*, .avs_byteenable(4'hF), .tx_push({ev[1], ev[0] | dma_push}),
    .tx_pop(ev[3:2]), .rx_push(ev[5:4]), .rx_pop(ev[7:6]), .rx_timeout(ev[9:8]),
    .tx_space_ready_n(txr_n), .multi_function_pin(mfp));
  ufd_dma ufd_dma_inst (.clk(clk), .en(dma_en), .ready_n(txr_n[0]), .push(dma_push));
  initial forever #4 clk = ~clk;
  function automatic logic [7:0] fcr_exp(input logic [7:0] o, input logic [7:0] v);
    return v[0] ? (v & 8'hC9) : (o & 8'hFE);
  endfunction
  function automatic logic [4:0] trig(input int c);
    return (c == 0) ? 5'h01 : (c == 1) ? 5'h04 : (c == 2) ? 5'h08 : 5'h0E;
  endfunction
  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    // The stall and the read data are sampled as they stood just before each rising edge.
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("wait", n < 20, 1'b1);
    if (n == 20)
      end_of_test();
    @(negedge clk);
  endtask
  task automatic pulse(input logic [9:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 10'h000;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    end_of_test();
  end
  initial begin
    void'($urandom(53));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk("txr", txr_n, 2'h0);
    chk("mfp", mfp, 2'h3);
    bus(1'b0, 4'h0, 8'h00);
    chk("fcr", q, 32'h0);
    pulse(10'h001);
    chk("txr", txr_n, 2'h1);
    pulse(10'h004);
    chk("txr", txr_n, 2'h0);
    pulse(10'h010);
    chk("mfp", mfp, 2'h3);
    bus(1'b1, 4'h2, 8'h01);
    pulse(10'h000);
    chk("mfp", mfp, 2'h2);
    pulse(10'h040);
    chk("mfp", mfp, 2'h3);
    $display("test mode0 done");
    f = 8'h00;
    for (k = 0; k < 8; k++) begin
      w = (k == 0) ? 8'hFF : 8'($urandom);
      bus(1'b1, 4'h0, w);
      f = fcr_exp(f, w);
      bus(1'b0, 4'h0, 8'h00);
      chk("fcr", q, f);
    end
    bus(1'b1, 4'h7, 8'hFF);
    bus(1'b0, 4'h7, 8'h00);
    chk("free", q, 32'h0);
    bus(1'b0, 4'h1, 8'h00);
    chk("fcrb", q, 32'h0);
    $display("test control done");
    for (t = 0; t < 4; t++) begin
      bus(1'b1, 4'h0, {t[1:0], 6'h0B});
      for (k = 1; k <= 17; k++) begin
        pulse(10'h010);
        if (k <= trig(t))
          chk("rxi", rx_irq[0], k == trig(t));
        chk("mfp", mfp[0], k < trig(t));
      end
      bus(1'b0, 4'h4, 8'h00);
      chk("cnt", q[22:10], 13'h1010);
      for (k = 16; k > 0; k--) begin
        chk("mfp", mfp[0], 1'b0);
        pulse(10'h040);
      end
      chk("mfp", mfp[0], 1'b1);
    end
    pulse(10'h010);
    chk("mfp", mfp[0], 1'b1);
    pulse(10'h100);
    chk("mfp", mfp[0], 1'b0);
    pulse(10'h040);
    chk("mfp", mfp[0], 1'b1);
    $display("test receive done");
    @(posedge clk);
    dma_en <= 1'b1;
    for (k = 0; k < 200 && txr_n[0] !== 1'b1; k++)
      @(negedge clk);
    chk("dma", k < 200, 1'b1);
    if (k == 200)
      end_of_test();
    @(posedge clk);
    dma_en <= 1'b0;
    pulse(10'h000);
    chk("txr", txr_n, 2'h1);
    chk("txi", tx_irq[0], 1'b0);
    bus(1'b0, 4'h4, 8'h00);
    chk("cnt", q[4:0], 5'h10);
    pulse(10'h004);
    chk("txr", txr_n, 2'h0);
    chk("txi", tx_irq[0], 1'b1);
    bus(1'b1, 4'h0, 8'hCD);
    bus(1'b0, 4'h4, 8'h00);
    chk("cnt", q[4:0], 5'h00);
    bus(1'b0, 4'h0, 8'h00);
    chk("fcr", q, 32'hC9);
    $display("test transmit done");
    bus(1'b1, 4'h6, 8'h00);
    bus(1'b1, 4'h0, 8'h0B);
    bus(1'b1, 4'h5, 8'h3F);
    pulse(10'h010);
    bus(1'b0, 4'h5, 8'h00);
    chk("ist", q[1], 1'b1);
    chk("irq", irq, 1'b0);
    bus(1'b1, 4'h6, 8'h02);
    pulse(10'h000);
    chk("irq", irq, 1'b1);
    bus(1'b1, 4'h5, 8'h02);
    pulse(10'h000);
    chk("irq", irq, 1'b0);
    $display("test interrupt done");
    end_of_test();
  end
endmodule
`default_nettype wire
